// file: test_tmr_counter.sv
`timescale 1ns/100ps
module test_tmr_counter;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, companion_osc_enable = 1'b0, run_ext = 1'b0, err;
	logic fire = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic pready, pslverr, ext_clk_pin, companion_osc_clk, first_compare_match;
	logic overflow_irq, overflow_irq_priority;
	logic [3:0] first_compare_mode_field, second_compare_mode_field;
	logic [7:0] second_compare_value_high, second_compare_value_low;
	logic [15:0] count_value, period = 16'h0, c0;
	int fails = 0, check_count = 0, cyc = 0, seed = 32'h834ddf10, per, k, mx;

	tmr_counter DUT (.*);
	tmr_partner far_end (.*);

	initial forever #2.5 pclk = ~pclk;

	// ----------------
	// helpers
	// ----------------
	function automatic int tick_per(int p);
		return 4 << p;
	endfunction
	function automatic int rises(int w, int half);
		return w / (2 * half);
	endfunction
	task automatic xfer(input logic w, input logic [11:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// cycles between two visible ticks
	task automatic measure(output int p);
		c0 = count_value;
		for (k = 0; count_value === c0 && k < 300; k++) @(posedge pclk);
		c0 = count_value;
		for (p = 0; count_value === c0 && p < 300; p++) @(posedge pclk);
	endtask
	task automatic summarize;
		$display("fails %0d checks %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, run needs about 1300 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize;
		end
	end

	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(0, 12'h000, 0);
		cmp("ctrl reset", 0, rd);
		xfer(0, 12'h018, 0);
		cmp("unmapped", 1, err);
		xfer(1, 12'h014, 2);
		xfer(0, 12'h014, 0);
		cmp("priority", 2, rd);
		cmp("priority pin", 1, overflow_irq_priority);
		r = $random(seed);
		xfer(1, 12'h008, r[15:8]);
		xfer(1, 12'h004, r[7:0]);
		cmp("narrow count", r[15:0], count_value);
		$display("reset and narrow done");
		xfer(1, 12'h000, 32'h80);
		xfer(1, 12'h008, 32'hab);
		cmp("live high kept", r[15:0], count_value);
		xfer(1, 12'h004, 32'hcd);
		cmp("wide load", 32'habcd, count_value);
		xfer(1, 12'h008, 32'h55);
		xfer(0, 12'h008, 0);
		cmp("buffer read", 32'h55, rd);
		xfer(0, 12'h004, 0);
		xfer(0, 12'h008, 0);
		cmp("high copy", 32'hab, rd);
		$display("wide access done");
		for (int p = 0; p < 4; p++) begin
			xfer(1, 12'h000, 32'h01 | p << 4);
			measure(per);
			cmp("tick period", tick_per(p), per);
		end
		xfer(1, 12'h010, 2);
		xfer(1, 12'h000, 32'h80);
		xfer(1, 12'h008, 32'hff);
		xfer(1, 12'h004, 32'hf0);
		xfer(1, 12'h000, 32'h81);
		for (k = 0; overflow_irq !== 1'b1 && k < 500; k++) @(posedge pclk);
		cmp("irq raised", 1, overflow_irq);
		cmp("wrapped", 0, count_value[15:4]);
		xfer(1, 12'h000, 0);
		c0 = count_value;
		repeat (40) @(posedge pclk);
		cmp("held", c0, count_value);
		xfer(1, 12'h00c, 0);
		cmp("irq cleared", 0, overflow_irq);
		xfer(1, 12'h010, 0);
		xfer(1, 12'h008, 32'hff);
		xfer(1, 12'h004, 32'hf8);
		xfer(1, 12'h000, 1);
		repeat (60) @(posedge pclk);
		cmp("masked irq", 0, overflow_irq);
		xfer(0, 12'h00c, 0);
		cmp("flag latched", 2, rd);
		xfer(1, 12'h00c, 0);
		$display("overflow done");
		period <= 16'h4 + 16'($random(seed) & 15);
		xfer(1, 12'h008, 0);
		xfer(1, 12'h004, 0);
		xfer(1, 12'h000, 32'h41);
		mx = 0;
		repeat (400) begin
			@(posedge pclk);
			if (count_value > mx) mx = count_value;
		end
		cmp("period top", period, mx);
		xfer(0, 12'h00c, 0);
		cmp("trigger flag", 0, rd);
		period <= 16'h0;
		xfer(1, 12'h000, 32'hc0);
		xfer(1, 12'h008, 32'h12);
		// first unit fires on the very edge at which the write lands
		fork
			xfer(1, 12'h004, 32'h77);
			begin
				repeat (2) @(posedge pclk);
				fire <= 1'b1;
				@(posedge pclk);
				fire <= 1'b0;
			end
		join
		cmp("write beats trigger", 32'h1277, count_value);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp("unit one reset", 0, count_value);
		$display("trigger done");
		for (int m = 0; m < 4; m++) begin
			companion_osc_enable <= m[0];
			// source first, so no internal tick lands after the clear
			xfer(1, 12'h000, m[1] ? 32'h07 : 32'h03);
			xfer(1, 12'h008, 0);
			xfer(1, 12'h004, 0);
			run_ext <= 1'b1;
			repeat (60) @(posedge pclk);
			run_ext <= 1'b0;
			repeat (10) @(posedge pclk);
			cmp("ext count", rises(60, m[0] ? 3 : 5), count_value);
		end
		// unsynchronised counting runs straight through the period
		period <= 16'h3;
		xfer(1, 12'h000, 32'h4f);
		xfer(1, 12'h008, 0);
		xfer(1, 12'h004, 0);
		run_ext <= 1'b1;
		repeat (60) @(posedge pclk);
		run_ext <= 1'b0;
		repeat (10) @(posedge pclk);
		cmp("no async reset", rises(60, 3), count_value);
		$display("external done");
		summarize;
	end
endmodule // test_tmr_counter

// file: tmr_chk.sv
`timescale 1ns/100ps
module tmr_chk (
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status
	input wire logic [15:0] count_value,
	input wire logic overflow_irq,
	input wire logic overflow_irq_priority
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	// a write lands at the edge that samples pready
	assign wr = pready && pwrite;
	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence
	a_ready_wait: assert property (s_setup |-> !pready ##1 pready ##1 !pready)
		else $error("answer not after one wait state");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_map: assert property (pready |->
		pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
		else $error("error response wrong");
	a_count_step: assert property ($changed(count_value) && !$past(wr) &&
		count_value != 16'h0 |-> count_value == $past(count_value) + 16'h1)
		else $error("count skipped");
	a_count_wrap: assert property ($past(count_value) == 16'hffff &&
		$changed(count_value) && !$past(wr) |-> count_value == 16'h0)
		else $error("no wrap to zero");
	a_irq_hold: assert property ($fell(overflow_irq) |->
		$past(wr) || $past(wr, 2))
		else $error("irq dropped without write");
	a_irq_cause: assert property ($rose(overflow_irq) |-> $past(wr) ||
		$past(wr, 2) || ($past(count_value) == 16'hffff && count_value == 0)
		|| ($past(count_value, 2) == 16'hffff && $past(count_value) == 0))
		else $error("irq without cause");
	a_prio_write: assert property ($changed(overflow_irq_priority) |->
		$past(wr) && $past(paddr) == 12'h014)
		else $error("priority moved alone");
endmodule // tmr_chk

bind tmr_counter tmr_chk chk (.*);

// file: tmr_counter.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "tmr_defs.svh"
// Overview of operation
// - wide mode: high byte address reaches the high byte buffer instead.
// - wide mode: low byte read copies live high byte into buffer.
// - wide mode: low byte write loads live high byte from buffer.
// - wide mode: live high byte never read or written directly.
// - only low byte writes clear the prescaler.
// - counter counts up 0000h to ffffh, wraps, wrap is overflow.
// - overflow sets sticky flag; interrupt only when enable bit set.
// - special event compare mode 1011 on match resets counter.
// - trigger reset works in timer and sync counter modes only.
// - second unit compare value acts as the counter period.
// - software write in same cycle as trigger wins over reset.
// - trigger reset never sets the overflow flag.
// - internal source advances once per instruction cycle, pclk/4.
// - prescale field divides by one, two, four or eight.
// - external input is synchronised whatever the sync control; set only drops the trigger reset.

module tmr_counter (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external clock pins
	input wire logic ext_clk_pin,
	input wire logic companion_osc_clk,
	input wire logic companion_osc_enable,
	// capture/compare units
	input wire logic [3:0] first_compare_mode_field,
	input wire logic first_compare_match,
	input wire logic [3:0] second_compare_mode_field,
	input wire logic [7:0] second_compare_value_high,
	input wire logic [7:0] second_compare_value_low,
	// status out
	output logic [15:0] count_value,
	output logic overflow_irq,
	output logic overflow_irq_priority
);
	import tmr_pkg::*;

	tmr_state_t s_q;
	tmr_state_t s_d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------

	// prescaler terminal count for a 2-bit select
	function automatic logic [2:0] pre_last(input logic [1:0] sel);
		pre_last = 3'((4'h1 << sel) - 4'h1);
	endfunction

	// one-word register read view
	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------

	logic wide;
	logic ext_sel;
	logic async_mode;
	logic run;
	logic [1:0] psel_fld;
	logic access;
	logic wr_done;
	logic rd_first;
	logic hit_ctl;
	logic hit_lo;
	logic hit_hi;
	logic hit_flg;
	logic hit_ien;
	logic hit_pri;
	logic mapped;
	logic unit1_ours;
	logic unit2_ours;
	logic [15:0] period;
	logic trig;
	logic src_edge;
	logic cnt_tick;

	// control field views and bus phase
	always_comb begin
		wide = s_q.ctrl[`CTL_WIDE_ACCESS];
		ext_sel = s_q.ctrl[`CTL_CLK_SOURCE];
		async_mode = ext_sel & s_q.ctrl[`CTL_EXT_SYNC];
		run = s_q.ctrl[`CTL_RUN];
		psel_fld = s_q.ctrl[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
		access = psel & penable;
		// write lands at the edge where pready is seen high
		wr_done = access & s_q.pready & pwrite;
		// read data is prepared on the first access edge
		rd_first = access & ~s_q.pready & ~pwrite;
		hit_ctl = (paddr == `OFS_COUNTER_CONTROL);
		hit_lo = (paddr == `OFS_COUNT_LOW_BYTE);
		hit_hi = (paddr == `OFS_COUNT_HIGH_BYTE);
		hit_flg = (paddr == `OFS_FLAG_GROUP_TWO);
		hit_ien = (paddr == `OFS_ENABLE_GROUP_TWO);
		hit_pri = (paddr == `OFS_PRIORITY_GROUP_TWO);
		mapped = hit_ctl | hit_lo | hit_hi | hit_flg | hit_ien | hit_pri;
	end

	// special event trigger from either compare unit
	always_comb begin
		// 1x: both units on this counter, 01: only the second
		unit1_ours = s_q.ctrl[`CTL_TIMEBASE_HI];
		unit2_ours = s_q.ctrl[`CTL_TIMEBASE_HI] |
			s_q.ctrl[`CTL_TIMEBASE_LO];
		period = {second_compare_value_high, second_compare_value_low};
		trig = 1'b0;
		if (unit1_ours && first_compare_match &&
			first_compare_mode_field == `SPECIAL_TRIG_MODE) begin
			trig = 1'b1;
		end
		// count reaching the compare value restarts it from zero;
		// the compare sees the live count, so the top value stands one pclk
		if (unit2_ours && s_q.count == period &&
			second_compare_mode_field == `SPECIAL_TRIG_MODE) begin
			trig = 1'b1;
		end
		// unsynchronised counting gives no trigger reset
		if (async_mode) begin
			trig = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// pins pass two flops; the third only feeds edge detect
		s_d.sync1 = {companion_osc_clk, ext_clk_pin};
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		// oscillator replaces the pin when enabled
		if (companion_osc_enable) begin
			src_edge = s_q.sync2[1] & ~s_q.sync3[1];
		end else begin
			src_edge = s_q.sync2[0] & ~s_q.sync3[0];
		end
		// one clock only: the unsynchronised mode shares the sync path,
		// it differs just in losing the trigger reset
		if (async_mode) begin
			src_edge = s_q.sync2[0] & ~s_q.sync3[0] & ~companion_osc_enable |
				s_q.sync2[1] & ~s_q.sync3[1] & companion_osc_enable;
		end

		// instruction cycle divider always runs
		s_d.div = 2'(s_q.div + 2'h1);
		if (!ext_sel) begin
			src_edge = (s_q.div == 2'(`INSTR_DIV - 1));
		end

		// prescaler in front of the counter
		cnt_tick = 1'b0;
		if (run && src_edge) begin
			if (s_q.pre >= pre_last(psel_fld)) begin
				s_d.pre = 3'h0;
				cnt_tick = 1'b1;
			end else begin
				s_d.pre = 3'(s_q.pre + 3'h1);
			end
		end

		// counting, wrap and trigger reset
		if (trig) begin
			s_d.count = `COUNT_RESET;
		end else if (cnt_tick) begin
			s_d.count = 16'(s_q.count + 16'h0001);
			if (s_q.count == `COUNT_MAX) begin
				s_d.flag = 1'b1;
			end
		end

		// bus: one wait state, then pready for one cycle
		// no back-pressure: every access answers after the same wait
		s_d.pready = access & ~s_q.pready;
		s_d.pslverr = access & ~s_q.pready & ~mapped;
		if (!access || s_q.pready) begin
			s_d.prdata = 32'h00000000;
		end

		// read path; the copy happens with the low byte sample
		if (rd_first) begin
			if (hit_ctl) begin
				s_d.prdata = byte_word(s_q.ctrl);
			end
			if (hit_lo) begin
				s_d.prdata = byte_word(s_q.count[7:0]);
				if (wide) begin
					s_d.hbuf = s_q.count[15:8];
				end
			end
			if (hit_hi) begin
				if (wide) begin
					s_d.prdata = byte_word(s_q.hbuf);
				end else begin
					s_d.prdata = byte_word(s_q.count[15:8]);
				end
			end
			if (hit_flg) begin
				s_d.prdata = 32'(s_q.flag) << `OVF_BIT;
			end
			if (hit_ien) begin
				s_d.prdata = 32'(s_q.ien) << `OVF_BIT;
			end
			if (hit_pri) begin
				s_d.prdata = 32'(s_q.iprio) << `OVF_BIT;
			end
		end

		// write path; it overrides the count update above
		if (wr_done) begin
			if (hit_ctl) begin
				s_d.ctrl = pwdata[7:0];
			end
			if (hit_lo) begin
				s_d.pre = 3'h0;
				if (wide) begin
					s_d.count = {s_q.hbuf, pwdata[7:0]};
				end else begin
					s_d.count[7:0] = pwdata[7:0];
					// keep the live high byte only if no trigger hit it
					s_d.count[15:8] = trig ? 8'h00 : s_q.count[15:8];
					if (!trig && cnt_tick && s_q.count[7:0] == 8'hff) begin
						s_d.count[15:8] = 8'(s_q.count[15:8] + 8'h01);
					end
				end
			end
			if (hit_hi) begin
				// prescaler is left alone here
				if (wide) begin
					s_d.hbuf = pwdata[7:0];
				end else begin
					s_d.count[15:8] = pwdata[7:0];
					s_d.count[7:0] = trig ? 8'h00 : s_q.count[7:0];
					if (!trig && cnt_tick) begin
						s_d.count[7:0] = 8'(s_q.count[7:0] + 8'h01);
					end
				end
			end
			// clearing loses to an overflow in the same cycle
			if (hit_flg) begin
				// software value first, a wrap in this cycle sets it again
				s_d.flag = pwdata[`OVF_BIT];
				if (!pwdata[`OVF_BIT] && cnt_tick && !trig &&
					s_q.count == `COUNT_MAX) begin
					s_d.flag = 1'b1;
				end
			end
			if (hit_ien) begin
				s_d.ien = pwdata[`OVF_BIT];
			end
			if (hit_pri) begin
				s_d.iprio = pwdata[`OVF_BIT];
			end
		end

		// registered status outputs
		s_d.irq = s_d.flag & s_d.ien;
		s_d.count_out = s_d.count;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= `CONTROL_RESET;
			s_q.count <= `COUNT_RESET;
			s_q.count_out <= `COUNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign count_value = s_q.count_out;
	assign overflow_irq = s_q.irq;
	assign overflow_irq_priority = s_q.iprio;

endmodule // tmr_counter

// file: tmr_defs.svh
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_COUNTER_CONTROL 12'h000
`define OFS_COUNT_LOW_BYTE 12'h004
`define OFS_COUNT_HIGH_BYTE 12'h008
`define OFS_FLAG_GROUP_TWO 12'h00c
`define OFS_ENABLE_GROUP_TWO 12'h010
`define OFS_PRIORITY_GROUP_TWO 12'h014

// ---------------------------------------------------------------
// counter_control field positions
// ---------------------------------------------------------------
`define CTL_WIDE_ACCESS 7
`define CTL_TIMEBASE_HI 6
`define CTL_PRESCALE_HI 5
`define CTL_PRESCALE_LO 4
`define CTL_TIMEBASE_LO 3
`define CTL_EXT_SYNC 2
`define CTL_CLK_SOURCE 1
`define CTL_RUN 0

// overflow bit position in the group-two flag, enable, priority regs
`define OVF_BIT 1

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define CONTROL_RESET 8'h00
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define SPECIAL_TRIG_MODE 4'hb
// pclk cycles per instruction cycle
`define INSTR_DIV 4

`endif

// file: tmr_partner.sv
`timescale 1ns/100ps
module tmr_partner (
	// from the bench
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run_ext,
	input wire logic [15:0] period,
	input wire logic fire,
	// toward the timer
	output logic ext_clk_pin,
	output logic companion_osc_clk,
	output logic [3:0] first_compare_mode_field,
	output logic first_compare_match,
	output logic [3:0] second_compare_mode_field,
	output logic [7:0] second_compare_value_high,
	output logic [7:0] second_compare_value_low
);
	logic [7:0] cnt_q;
	// phase counter; both clocks stand low outside bursts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 8'h00;
		else
			cnt_q <= run_ext ? cnt_q + 8'h01 : 8'h00;
	end
	// pin period 10, oscillator period 6, so selection shows
	assign ext_clk_pin = run_ext && (cnt_q % 10) >= 5;
	assign companion_osc_clk = run_ext && (cnt_q % 6) >= 3;
	// second unit compares only when a period is given
	// first unit always in trigger mode, matches only when fired
	assign first_compare_mode_field = 4'hb;
	assign first_compare_match = fire;
	assign second_compare_mode_field = period != 0 ? 4'hb : 4'h0;
	assign {second_compare_value_high, second_compare_value_low} = period;
endmodule // tmr_partner

// file: tmr_pkg.sv
package tmr_pkg;

	// all state of the timer block
	typedef struct packed {
		logic [1:0] div;
		logic [2:0] pre;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] sync3;
		logic [15:0] count;
		logic [7:0] hbuf;
		logic [7:0] ctrl;
		logic flag;
		logic ien;
		logic iprio;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
		logic [15:0] count_out;
	} tmr_state_t;

endpackage
